// file: design/rcps_pkg.sv
// rcps_pkg: shared constants for the reset configuration pin sampler
// assumes: one 100 MHz platform clock; no software-visible registers
package rcps_pkg;
    // widths of the strap groups
    localparam int PULLED_W = 8;
    localparam int RATIO_W = 4;
    // default decode for pulled-up straps: a high level means default
    localparam logic [PULLED_W-1:0] PULLED_DEFAULT = 8'hFF;
    // clock figures
    localparam int CLK_PERIOD_NS = 10;
    // pull-up hold after release, in platform clock cycles
    localparam int PU_HOLD_CYC = 4;
    localparam int PU_HOLD_W = 3;
    // tap reset by tms: five tck rising edges with tms high
    localparam int TAP_RST_CNT = 5;
    localparam int TAP_CNT_W = 3;
    localparam logic [TAP_CNT_W-1:0] TAP_CNT_ZERO = 3'h0;
endpackage : rcps_pkg

// file: design/rcps_sampler.sv
// rcps_sampler: captures strap levels at the release of hard reset and owns
// the pad controls of the strap pins, plus the reset duties of the test port
// assumes: straps are pins (synchronised here); test clock pins are sampled
// on mclk_i, so tck must be well below half the platform clock
`timescale 1ns/1ps
module rcps_sampler #(
    parameter int PULLED_W = rcps_pkg::PULLED_W,
    parameter int RATIO_W = rcps_pkg::RATIO_W
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // hard reset pin, already merged with debug port sources on the board
    input wire logic hard_reset_n_i,
    input wire logic soft_reset_n_i,
    input wire logic test_reset_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    // pulled-up strap pads
    input wire logic [PULLED_W-1:0] pulled_pad_i,
    input wire logic [PULLED_W-1:0] pulled_func_i,
    output logic [PULLED_W-1:0] pulled_pad_o,
    output logic [PULLED_W-1:0] pulled_pad_oe_o,
    output logic [PULLED_W-1:0] pulled_pu_en_o,
    output logic [PULLED_W-1:0] pulled_rx_en_o,
    // ratio strap pads, no pull-up
    input wire logic [RATIO_W-1:0] ratio_pad_i,
    input wire logic [RATIO_W-1:0] ratio_func_i,
    output logic [RATIO_W-1:0] ratio_pad_o,
    output logic [RATIO_W-1:0] ratio_pad_oe_o,
    output logic [RATIO_W-1:0] ratio_rx_en_o,
    // captured settings
    output logic [PULLED_W-1:0] cfg_pulled_o,
    output logic [PULLED_W-1:0] cfg_nondefault_o,
    output logic [RATIO_W-1:0] cfg_ratio_o,
    output logic cfg_valid_o,
    // core and test port controls
    output logic core_reset_n_o,
    output logic machine_check_o,
    output logic tap_reset_o
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    localparam int SW = 5 + PULLED_W + RATIO_W;
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic hrst_n_s, srst_n_s, trst_n_s, tck_s, tms_s;
    logic [PULLED_W-1:0] pulled_s;
    logic [RATIO_W-1:0] ratio_s;

    assign raw = {hard_reset_n_i, soft_reset_n_i, test_reset_n_i, tck_i, tms_i,
                  pulled_pad_i, ratio_pad_i};

    // resets synchronise as asserted so nothing is captured before a real release
    // tck idles high on a board without a probe, so its stage resets high: no false rise
    rcps_sync #(
        .W(SW),
        .RST_VAL({3'h0, 1'b1, {(SW - 4){1'b0}}})
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i(raw),
        .q_o(syn)
    );

    assign {hrst_n_s, srst_n_s, trst_n_s, tck_s, tms_s, pulled_s, ratio_s} = syn;

    // ------------------------------------------------------------
    // capture sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RCPS_IN_RESET, RCPS_PU_HOLD, RCPS_RUN} rcps_state_t;
    rcps_state_t state_q, state_d;
    logic [rcps_pkg::PU_HOLD_W-1:0] hold_q, hold_d;
    logic [PULLED_W-1:0] cap_pulled_q, cap_pulled_d;
    logic [RATIO_W-1:0] cap_ratio_q, cap_ratio_d;
    logic hrst_n_prev_q;
    logic release_w;
    logic in_reset_w;
    logic rx_on_w;
    logic hold_done_w;

    assign release_w = hrst_n_s & ~hrst_n_prev_q;
    assign in_reset_w = ~hrst_n_s;
    assign hold_done_w = (hold_q == rcps_pkg::PU_HOLD_W'(rcps_pkg::PU_HOLD_CYC - 1));
    // receiver stays on through the hold window; it ends with the pull-up
    assign rx_on_w = (state_q != RCPS_RUN);

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        cap_pulled_d = cap_pulled_q;
        cap_ratio_d = cap_ratio_q;
        case (state_q)
            RCPS_IN_RESET: begin
                hold_d = '0;
                if (release_w) begin
                    // level present at release is the setting
                    cap_pulled_d = pulled_s;
                    cap_ratio_d = ratio_s;
                    state_d = RCPS_PU_HOLD;
                end
            end
            RCPS_PU_HOLD: begin
                hold_d = hold_q + 1'b1;
                if (in_reset_w) begin
                    state_d = RCPS_IN_RESET;
                end else if (hold_done_w) begin
                    state_d = RCPS_RUN;
                end
            end
            RCPS_RUN: begin
                // pins toggle freely now; capture registers are untouched
                if (in_reset_w) begin
                    state_d = RCPS_IN_RESET;
                end
            end
            default: state_d = RCPS_IN_RESET;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= RCPS_IN_RESET;
            hold_q <= '0;
            cap_pulled_q <= rcps_pkg::PULLED_DEFAULT;
            cap_ratio_q <= '0;
            hrst_n_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            cap_pulled_q <= cap_pulled_d;
            cap_ratio_q <= cap_ratio_d;
            hrst_n_prev_q <= hrst_n_s;
        end
    end

    // ------------------------------------------------------------
    // pad control
    // ------------------------------------------------------------
    logic [PULLED_W-1:0] pulled_out_q;
    logic [RATIO_W-1:0] ratio_out_q;
    logic drive_q;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulled_out_q <= '0;
            ratio_out_q <= '0;
            drive_q <= 1'b0;
        end else begin
            pulled_out_q <= pulled_func_i;
            ratio_out_q <= ratio_func_i;
            drive_q <= (state_d == RCPS_RUN);
        end
    end

    assign pulled_pad_o = pulled_out_q;
    assign ratio_pad_o = ratio_out_q;
    assign pulled_pad_oe_o = {PULLED_W{drive_q & ~in_reset_w}};
    assign ratio_pad_oe_o = {RATIO_W{drive_q & ~in_reset_w}};
    assign pulled_rx_en_o = {PULLED_W{rx_on_w}};
    // pull-up follows the receiver exactly
    assign pulled_pu_en_o = {PULLED_W{rx_on_w}};
    // ratio pins have no pull-up output at all; the board must drive them
    assign ratio_rx_en_o = {RATIO_W{rx_on_w}};

    // ------------------------------------------------------------
    // settings out
    // ------------------------------------------------------------
    assign cfg_pulled_o = cap_pulled_q;
    // a high strap is default, so a low one marks a non-default choice
    assign cfg_nondefault_o = ~cap_pulled_q;
    assign cfg_ratio_o = cap_ratio_q;
    assign cfg_valid_o = (state_q == RCPS_RUN);

    // ------------------------------------------------------------
    // soft reset and test port reset
    // ------------------------------------------------------------
    logic mc_q;
    logic tck_prev_q;
    logic [rcps_pkg::TAP_CNT_W-1:0] tms_cnt_q;
    logic tap_rst_q;
    logic tck_rise_w;
    logic tms_seq_w;

    assign tck_rise_w = tck_s & ~tck_prev_q;
    assign tms_seq_w = (tms_cnt_q == rcps_pkg::TAP_CNT_W'(rcps_pkg::TAP_RST_CNT - 1));

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mc_q <= 1'b0;
            tck_prev_q <= 1'b1;
            tms_cnt_q <= rcps_pkg::TAP_CNT_ZERO;
            tap_rst_q <= 1'b1;
        end else begin
            // machine check, not a reset; held while soft reset is low and hard reset is released
            mc_q <= ~srst_n_s & hrst_n_s;
            tck_prev_q <= tck_s;
            if (tck_rise_w) begin
                if (!tms_s) begin
                    tms_cnt_q <= rcps_pkg::TAP_CNT_ZERO;
                end else if (!tms_seq_w) begin
                    tms_cnt_q <= tms_cnt_q + 1'b1;
                end
            end
            // test-access reset pin and tms sequence reset the tap independently
            tap_rst_q <= ~trst_n_s | (tck_rise_w & tms_s & tms_seq_w);
        end
    end

    assign machine_check_o = mc_q;
    assign tap_reset_o = tap_rst_q;
    // soft reset never reaches the core reset
    assign core_reset_n_o = hrst_n_s;
endmodule : rcps_sampler

// file: design/rcps_sync.sv
// rcps_sync: two-stage synchroniser for a bus of asynchronous levels
// assumes: inputs come from pins or another clock; output is in mclk_i domain
`timescale 1ns/1ps
module rcps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage is read only by the second
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : rcps_sync

// file: dv/rcps_board.sv
// rcps_board: strap resistors on the board side of the strap pins
// assumes: device drive wins over resistors; unpulled idle pin reads low
`timescale 1ns/1ps
module rcps_board (
    input wire logic [7:0] pd_i,
    input wire logic [3:0] ratio_strap_i,
    input wire logic [7:0] pulled_out_i,
    input wire logic [7:0] pulled_oe_i,
    input wire logic [7:0] pulled_pu_i,
    input wire logic [3:0] ratio_out_i,
    input wire logic [3:0] ratio_oe_i,
    output logic [7:0] pulled_wire_o,
    output logic [3:0] ratio_wire_o
);
    // ----------------------------------------
    // wire resolution
    // ----------------------------------------
    // pull-down beats the weak pull-up; with both off the pin is not left at 1
    assign pulled_wire_o = (pulled_oe_i & pulled_out_i) | (~pulled_oe_i & ~pd_i & pulled_pu_i);
    // no internal pull-up on ratio pins: board drives every one of them
    assign ratio_wire_o = (ratio_oe_i & ratio_out_i) | (~ratio_oe_i & ratio_strap_i);
endmodule : rcps_board

// file: dv/rcps_sampler_props.sv
// rcps_sampler_props: pin, capture and reset checks on the sampler ports
// assumes: one mclk_i domain, rst_b_i async active low
`timescale 1ns/1ps
module rcps_sampler_props #(
    parameter int PULLED_W = 8,
    parameter int RATIO_W = 4
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic hard_reset_n_i,
    input wire logic soft_reset_n_i,
    input wire logic test_reset_n_i,
    input wire logic [PULLED_W-1:0] pulled_func_i,
    input wire logic [PULLED_W-1:0] pulled_pad_i,
    input wire logic [RATIO_W-1:0] ratio_pad_i,
    input wire logic [PULLED_W-1:0] pulled_pad_o,
    input wire logic [PULLED_W-1:0] pulled_pad_oe_o,
    input wire logic [PULLED_W-1:0] pulled_pu_en_o,
    input wire logic [PULLED_W-1:0] pulled_rx_en_o,
    input wire logic [RATIO_W-1:0] ratio_pad_oe_o,
    input wire logic [PULLED_W-1:0] cfg_pulled_o,
    input wire logic [PULLED_W-1:0] cfg_nondefault_o,
    input wire logic [RATIO_W-1:0] cfg_ratio_o,
    input wire logic cfg_valid_o,
    input wire logic core_reset_n_o,
    input wire logic machine_check_o,
    input wire logic tap_reset_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // pull-up must cover the capture edge, then drop within a few cycles
    sequence s_pu_on;
        (pulled_pu_en_o == '1) [*4];
    endsequence
    sequence s_pu_off;
        pulled_pu_en_o == '0;
    endsequence
    a_no_drive_reset: assert property (!core_reset_n_o |->
        pulled_pad_oe_o == '0 && ratio_pad_oe_o == '0) else $error("strap pin driven in reset");
    a_pu_in_reset: assert property (!core_reset_n_o && !$past(core_reset_n_o) |->
        pulled_pu_en_o == '1 && pulled_rx_en_o == '1) else $error("pull-up off in reset");
    a_pu_hold_window: assert property ($rose(core_reset_n_o) |->
        s_pu_on ##[1:3] s_pu_off) else $error("pull-up hold window wrong");
    a_pu_with_rx: assert property (pulled_pu_en_o == pulled_rx_en_o)
        else $error("pull-up and receiver differ");
    a_run_pin_mode: assert property (cfg_valid_o && core_reset_n_o |->
        pulled_rx_en_o == '0 && pulled_pad_oe_o == '1 && ratio_pad_oe_o == '1)
        else $error("pin not in output mode after capture");
    a_pad_follows_func: assert property (cfg_valid_o && $past(cfg_valid_o) |->
        pulled_pad_o == $past(pulled_func_i)) else $error("pad output not functional");
    a_cfg_held: assert property (cfg_valid_o && $past(cfg_valid_o) |->
        $stable(cfg_pulled_o) && $stable(cfg_ratio_o)) else $error("captured value changed");
    a_nondef_decode: assert property (cfg_nondefault_o == ~cfg_pulled_o)
        else $error("non-default decode wrong");
    a_soft_mcheck: assert property ((!soft_reset_n_i && core_reset_n_o) [*4] |->
        machine_check_o && core_reset_n_o) else $error("soft reset gave no machine check");
    a_trst_tap: assert property ((!test_reset_n_i) [*4] |-> tap_reset_o)
        else $error("tap not reset by test reset");
    // two synchroniser stages: the pin itself must stop the drive, not only the core reset
    a_pin_no_drive: assert property ((!hard_reset_n_i) [*3] |->
        pulled_pad_oe_o == '0 && ratio_pad_oe_o == '0) else $error("strap driven under pin reset");
    a_pin_pu_on: assert property ((!hard_reset_n_i) [*4] |->
        pulled_pu_en_o == '1 && pulled_rx_en_o == '1) else $error("pull-up off under pin reset");
    // capture edge is one cycle after the synced release; its pads were taken two stages back
    a_cap_release: assert property ($rose(core_reset_n_o) |=>
        cfg_pulled_o == $past(pulled_pad_i, 3) && cfg_ratio_o == $past(ratio_pad_i, 3))
        else $error("captured value not the release level");
endmodule : rcps_sampler_props
bind rcps_sampler rcps_sampler_props #(.PULLED_W(PULLED_W), .RATIO_W(RATIO_W)) u_props (.*);

// file: dv/tb_top.sv
// tb_top: strap capture, soft reset and tap reset scenarios for the sampler
// assumes: hard and test resets come from the probe, tied together at power-on
`timescale 1ns/1ps
module tb_top;
    logic mclk_i = 0, rst_b_i = 0, hard_reset_n_i = 0, soft_reset_n_i = 1;
    logic test_reset_n_i = 0, tck_i = 0, tms_i = 0, valid, corer, mchk, tapr;
    logic [7:0] pd = 8'h00, pfunc = 8'h00, ppo, poe, ppu, prx, cfgp, cfgn, ppad;
    logic [3:0] rstrap = 4'h0, rfunc = 4'h0, rpo, roe, rrx, cfgr, rpad;
    int errors = 0, samples_checked = 0, cyc = 0;
    always #5 mclk_i = ~mclk_i;
    rcps_sampler uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hard_reset_n_i(hard_reset_n_i),
        .soft_reset_n_i(soft_reset_n_i), .test_reset_n_i(test_reset_n_i), .tck_i(tck_i),
        .tms_i(tms_i), .pulled_pad_i(ppad), .pulled_func_i(pfunc), .pulled_pad_o(ppo),
        .pulled_pad_oe_o(poe), .pulled_pu_en_o(ppu), .pulled_rx_en_o(prx), .ratio_pad_i(rpad),
        .ratio_func_i(rfunc), .ratio_pad_o(rpo), .ratio_pad_oe_o(roe), .ratio_rx_en_o(rrx),
        .cfg_pulled_o(cfgp), .cfg_nondefault_o(cfgn), .cfg_ratio_o(cfgr), .cfg_valid_o(valid),
        .core_reset_n_o(corer), .machine_check_o(mchk), .tap_reset_o(tapr));
    rcps_board u_board (.pd_i(pd), .ratio_strap_i(rstrap), .pulled_out_i(ppo),
        .pulled_oe_i(poe), .pulled_pu_i(ppu), .ratio_out_i(rpo), .ratio_oe_i(roe),
        .pulled_wire_o(ppad), .ratio_wire_o(rpad));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // straps set under hard reset, captured at release, then disturbed
    task automatic strap_cap(input logic [7:0] p, input logic [3:0] r);
        int n;
        hard_reset_n_i = 0;
        test_reset_n_i = 0;
        step(4);
        pd = p;
        rstrap = r;
        step(4);
        chk("oe", 8'h00, poe);
        chk("ratio_oe", 8'h00, {4'h0, roe});
        chk("pu", 8'hFF, ppu);
        chk("ratio_rx", 8'h0F, {4'h0, rrx});
        hard_reset_n_i = 1;
        test_reset_n_i = 1;
        n = 0;
        while (valid !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        // two synchroniser stages, one detect edge, then the pull-up hold
        chk("rel_cyc", 8'(3 + rcps_pkg::PU_HOLD_CYC), n[7:0]);
        chk("cfg", ~p, cfgp);
        chk("nondef", p, cfgn);
        chk("ratio", {4'h0, r}, {4'h0, cfgr});
        chk("rx", 8'h00, prx);
        chk("pu_off", 8'h00, ppu);
        chk("ratio_rx_off", 8'h00, {4'h0, rrx});
        pd = ~p;
        rstrap = ~r;
        pfunc = p ^ 8'h3C;
        rfunc = r ^ 4'h9;
        step(2);
        chk("pad_o", p ^ 8'h3C, ppad);
        chk("ratio_pad", {4'h0, r ^ 4'h9}, {4'h0, rpad});
        chk("held", ~p, cfgp);
    endtask : strap_cap
    task automatic soft_check;
        soft_reset_n_i = 0;
        step(5);
        chk("mcheck", 8'h01, {7'h0, mchk});
        chk("core_rst", 8'h01, {7'h0, corer});
        soft_reset_n_i = 1;
        step(5);
        chk("mcheck_off", 8'h00, {7'h0, mchk});
    endtask : soft_check
    // tck is slow against mclk, four cycles a phase
    task automatic tap_seq;
        int seen;
        seen = 0;
        tms_i = 1;
        for (int i = 1; i <= 6; i++) begin
            for (int j = 0; j < 8; j++) begin
                tck_i = (j < 4 && i < 6);
                step(1);
                if (tapr === 1'b1) seen++;
            end
            if (i == 4) chk("tap_early", 8'h00, seen[7:0]);
        end
        chk("tap_pulse", 8'h01, seen[7:0]);
        tms_i = 0;
    endtask : tap_seq
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        step(3);
        rst_b_i = 1;
        strap_cap(8'h00, 4'hF);
        strap_cap(8'hA5, 4'h6);
        strap_cap(8'hFF, 4'h0);
        soft_check();
        tap_seq();
        wrap_up();
    end
endmodule : tb_top
